// File: pkg/spi_link_defs.svh
// Constants shared by both ends of the serial register-access link
`ifndef SPI_LINK_DEFS_SVH
`define SPI_LINK_DEFS_SVH
// Header byte codes
`define HDR_ADAD_NI 8'h40
`define HDR_ADAD_IL 8'h48
`define HDR_ADDD_RW 8'h43
`define HDR_ADDD_NI 8'h41
`define HDR_ADDD_IL 8'h49
// Address byte layout
`define RD_BIT 7
`define FIFO_TOP 7'h1F
`define REG_COUNT 128
`define LAST_BIT_IDX 3'h7
// Device register locations
`define SECOND_MODE_ADDR 7'h70
`define PAD_SEL_BIT 0
`define STATUS_ADDR 7'h71
// Strap capture delay after reset release
`define STRAP_WAIT 2'h2
// Controller register map
`define A_TX 4'h0
`define A_RX 4'h4
`define A_STAT 4'h8
`define A_DIV 4'hC
`define TX_LAST_BIT 8
`define DIV_RESET 16'h000A
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: pkg/spi_link_pkg.sv
// Types shared by both ends of the serial register-access link
`include "spi_link_defs.svh"
package spi_link_pkg;
  typedef enum logic [4:0] {
    IF_NONE = 5'h01, IF_PAR_STROBE = 5'h02, IF_PAR_PLAIN = 5'h04,
    IF_SERIAL = 5'h08, IF_MGMT = 5'h10
  } iface_t;
  typedef enum logic [6:0] {
    D_IDLE = 7'h01, D_HDR = 7'h02, D_ADDR = 7'h04, D_WDATA = 7'h08,
    D_RDSLOT = 7'h10, D_BWR = 7'h20, D_BRD = 7'h40
  } dev_st_t;
  typedef enum logic [4:0] {
    H_IDLE = 5'h01, H_LEAD = 5'h02, H_LOW = 5'h04, H_HIGH = 5'h08, H_HOLD = 5'h10
  } host_st_t;
  typedef struct packed {
    logic [1:0] sclk_s, cs_s, sdr_s, wr_s, rd_s, ale_s;
    logic sclk_p, cs_p;
    logic [1:0] cap_cnt;
    logic captured;
    iface_t iface;
    dev_st_t st;
    logic [7:0] hdr, sh, tx;
    logic [2:0] bitcnt;
    logic [6:0] addr;
    logic [4:0] ptr;
    logic drive, sdx_o, sdx_oe, int_o, int_oe;
    logic [`REG_COUNT-1:0][7:0] regs;
    logic wr_pulse;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
  } dev_state_t;
  typedef struct packed {
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [1:0] sdx_s;
    logic [15:0] div, cnt;
    host_st_t st;
    logic [2:0] bitcnt;
    logic [7:0] tx, rxsh, rx;
    logic last, rx_new, cs_n, sclk, serial_in_line;
  } host_state_t;
endpackage : spi_link_pkg

// File: pkg/spi_link_if.sv
// Four-wire serial link between controller and device
interface spi_link_if;
  // Clock, select and data lines
  logic sclk;
  logic cs_n;
  logic serial_in_line;
  logic sdx_o;
  logic sdx_oe;
  logic serial_out_line;
  // Pull-up on the output line covers open-drain and idle
  assign serial_out_line = sdx_oe ? sdx_o : 1'b1;
  modport dev (input sclk, input cs_n, input serial_in_line, input serial_out_line, output sdx_o, output sdx_oe);
  modport host (output sclk, output cs_n, output serial_in_line, input serial_out_line);
endinterface : spi_link_if

// File: rtl/spi_reg_dev.sv
// Device end: serial register-access port with strap capture and interrupt pin
// Operation
// - Straps sampled once at reset release
// - Board strobes parallel bus selection
// - Board ties strobes low for serial
// - Board ties unused pins high
// - Interrupt pin open-drain, low when requested
// - Link uses exactly four lines
// - Select falling edge starts access, header first
// - Sample on rising, shift on falling
// - Select rising edge ends the sequence
// - Bytes of eight bits, MSB first
// - Output pad open-drain or push-pull by bit
// - Header byte chooses sequence type
// - Header 40: pairs, drive only read slots
// - Non-interleaved read returns data next slot
// - Header 48: data overlaps next address
// - Interleaved data in following byte period
// - Header 43: pointer walks low range
// - Write address ends read part; here header 43 reads run on until select rises
`include "spi_link_defs.svh"
module spi_reg_dev (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial link
  spi_link_if.dev link,
  // Strap pins
  input wire logic wr_strap,
  input wire logic rd_strap,
  input wire logic ale_strap,
  // Interrupt sources and pin
  input wire logic [7:0] irq_src,
  output logic int_o,
  output logic int_oe,
  // Register file view
  output spi_link_pkg::iface_t iface,
  output logic out_pad_drive_select,
  output logic reg_wr_pulse,
  output logic [6:0] reg_wr_addr,
  output logic [7:0] reg_wr_data
);
  import spi_link_pkg::*;

  dev_state_t q;
  dev_state_t d;

  // Low range goes through the moving pointer
  function automatic logic [6:0] eff_addr(input logic [6:0] a, input logic [4:0] p);
    logic [4:0] s;
    s = a[4:0] + p;
    if (a <= `FIFO_TOP)
    begin
      eff_addr = {2'h0, s};
    end
    else
    begin
      eff_addr = a;
    end
  endfunction : eff_addr

  always_comb
  begin
    logic [7:0] rx;
    logic ld;
    logic [6:0] ld_a;
    logic wr;
    logic [6:0] wr_a;
    logic rise;
    logic fall;
    logic is_rd;
    rx = '0;
    ld = 1'b0;
    ld_a = '0;
    wr = 1'b0;
    wr_a = '0;
    is_rd = 1'b0;
    d = q;
    // Two-flop synchronisers for all pins
    d.sclk_s = {q.sclk_s[0], link.sclk};
    d.cs_s = {q.cs_s[0], link.cs_n};
    d.sdr_s = {q.sdr_s[0], link.serial_in_line};
    d.wr_s = {q.wr_s[0], wr_strap};
    d.rd_s = {q.rd_s[0], rd_strap};
    d.ale_s = {q.ale_s[0], ale_strap};
    d.sclk_p = q.sclk_s[1];
    d.cs_p = q.cs_s[1];
    rise = q.sclk_s[1] && !q.sclk_p;
    fall = !q.sclk_s[1] && q.sclk_p;
    d.wr_pulse = 1'b0;
    d.int_o = 1'b0;
    d.int_oe = |irq_src;
    // Wait for the synchronisers to settle before latching straps
    if (!q.captured)
    begin
      if (q.cap_cnt == `STRAP_WAIT)
      begin
        d.captured = 1'b1;
        if (q.wr_s[1] && q.rd_s[1] && q.cs_s[1])
        begin
          d.iface = q.ale_s[1] ? IF_PAR_STROBE : IF_PAR_PLAIN;
        end
        else if (!q.wr_s[1] && !q.rd_s[1] && !q.ale_s[1])
        begin
          d.iface = q.cs_s[1] ? IF_SERIAL : IF_MGMT;
        end
        else
        begin
          d.iface = IF_NONE;
        end
      end
      else
      begin
        d.cap_cnt = q.cap_cnt + 2'h1;
      end
    end
    if (q.iface != IF_SERIAL || q.cs_s[1])
    begin
      // Select high drops any partial byte and rearms the header
      d.st = D_HDR;
      d.bitcnt = '0;
      d.drive = 1'b0;
      d.sdx_oe = 1'b0;
      d.ptr = '0;
    end
    else if (q.cs_p)
    begin
      d.st = D_HDR;
      d.bitcnt = '0;
    end
    else if (rise)
    begin
      rx = {q.sh[6:0], q.sdr_s[1]};
      d.sh = rx;
      d.bitcnt = q.bitcnt + 3'h1;
      if (q.bitcnt == `LAST_BIT_IDX)
      begin
        is_rd = rx[`RD_BIT];
        case (q.st)
          D_HDR:
          begin
            d.hdr = rx;
            d.ptr = '0;
            if (rx == `HDR_ADAD_NI || rx == `HDR_ADAD_IL || rx == `HDR_ADDD_RW ||
                rx == `HDR_ADDD_NI || rx == `HDR_ADDD_IL)
            begin
              d.st = D_ADDR;
            end
            else
            begin
              d.st = D_IDLE;
            end
          end
          D_ADDR:
          begin
            d.addr = rx[6:0];
            if (is_rd)
            begin
              ld = 1'b1;
              if (q.hdr == `HDR_ADDD_RW)
              begin
                ld_a = eff_addr(rx[6:0], q.ptr);
                d.ptr = q.ptr + 5'h01;
                d.st = D_BRD;
              end
              else if (q.hdr == `HDR_ADAD_NI || q.hdr == `HDR_ADDD_NI)
              begin
                ld_a = rx[6:0];
                d.st = D_RDSLOT;
              end
              else
              begin
                // Next address may arrive while data goes out
                ld_a = rx[6:0];
                d.st = D_ADDR;
              end
            end
            else if (q.hdr == `HDR_ADAD_NI || q.hdr == `HDR_ADAD_IL)
            begin
              d.st = D_WDATA;
            end
            else
            begin
              d.st = D_BWR;
            end
          end
          D_WDATA:
          begin
            wr = 1'b1;
            wr_a = q.addr;
            d.st = D_ADDR;
          end
          D_RDSLOT:
          begin
            // Host stays silent in this slot
            d.st = D_ADDR;
          end
          D_BWR:
          begin
            wr = 1'b1;
            wr_a = eff_addr(q.addr, q.ptr);
            d.ptr = q.ptr + 5'h01;
          end
          D_BRD:
          begin
            ld = 1'b1;
            ld_a = eff_addr(q.addr, q.ptr);
            d.ptr = q.ptr + 5'h01;
          end
          default:
          begin
            d.st = D_IDLE;
          end
        endcase
        if (ld)
        begin
          d.tx = (ld_a == `STATUS_ADDR) ? irq_src : q.regs[ld_a];
          d.drive = 1'b1;
        end
        else
        begin
          // Release at once so a shared wire is free for the host
          d.drive = 1'b0;
          d.sdx_oe = 1'b0;
        end
        if (wr)
        begin
          d.regs[wr_a] = rx;
          d.wr_pulse = 1'b1;
          d.wr_addr = wr_a;
          d.wr_data = rx;
        end
      end
    end
    else if (fall && q.drive)
    begin
      d.sdx_o = q.tx[7];
      d.tx = {q.tx[6:0], 1'b0};
      if (q.regs[`SECOND_MODE_ADDR][`PAD_SEL_BIT])
      begin
        d.sdx_oe = 1'b1;
      end
      else
      begin
        d.sdx_oe = !q.tx[7];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.sclk_s <= 2'h3;
      q.cs_s <= 2'h3;
      q.sclk_p <= 1'b1;
      q.cs_p <= 1'b1;
      q.sdx_o <= 1'b1;
      q.iface <= IF_NONE;
      q.st <= D_HDR;
    end
    else
    begin
      q <= d;
    end
  end

  assign link.sdx_o = q.sdx_o;
  assign link.sdx_oe = q.sdx_oe;
  assign int_o = q.int_o;
  assign int_oe = q.int_oe;
  assign iface = q.iface;
  assign out_pad_drive_select = q.regs[`SECOND_MODE_ADDR][`PAD_SEL_BIT];
  assign reg_wr_pulse = q.wr_pulse;
  assign reg_wr_addr = q.wr_addr;
  assign reg_wr_data = q.wr_data;
endmodule : spi_reg_dev

// File: rtl/spi_reg_host.sv
// Controller end: AXI4-Lite driven byte engine for the serial link
`include "spi_link_defs.svh"
module spi_reg_host (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial link
  spi_link_if.host link,
  // AXI4-Lite write
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import spi_link_pkg::*;

  host_state_t q;
  host_state_t d;

  always_comb
  begin
    logic start;
    logic tick;
    logic [7:0] nb;
    logic [15:0] rl;
    start = 1'b0;
    nb = wdata[7:0];
    rl = q.div - 16'h0001;
    tick = (q.cnt == 16'h0000);
    d = q;
    d.sdx_s = {q.sdx_s[0], link.serial_out_line};
    d.awready = 1'b0;
    d.wready = 1'b0;
    d.arready = 1'b0;
    if (!tick)
    begin
      d.cnt = q.cnt - 16'h0001;
    end
    // Write channel: both halves taken together
    if (q.bvalid && bready)
    begin
      d.bvalid = 1'b0;
    end
    if (awvalid && wvalid && !q.bvalid && !q.awready)
    begin
      d.awready = 1'b1;
      d.wready = 1'b1;
      d.bvalid = 1'b1;
      d.bresp = `RESP_OKAY;
      if (awaddr == `A_TX)
      begin
        // A byte written while busy is dropped
        if (wstrb[0] && (q.st == H_IDLE || q.st == H_HOLD))
        begin
          start = 1'b1;
          d.last = wdata[`TX_LAST_BIT];
        end
      end
      else if (awaddr == `A_DIV)
      begin
        if (wdata[15:0] != 16'h0000)
        begin
          d.div = wdata[15:0];
        end
      end
      else if (awaddr != `A_RX && awaddr != `A_STAT)
      begin
        d.bresp = `RESP_SLVERR;
      end
    end
    // Read channel
    if (q.rvalid && rready)
    begin
      d.rvalid = 1'b0;
    end
    if (arvalid && !q.arready && !q.rvalid)
    begin
      d.arready = 1'b1;
      d.rvalid = 1'b1;
      d.rresp = `RESP_OKAY;
      d.rdata = '0;
      if (araddr == `A_RX)
      begin
        d.rdata = {24'h00_0000, q.rx};
        d.rx_new = 1'b0;
      end
      else if (araddr == `A_STAT)
      begin
        d.rdata = {30'h0000_0000, q.rx_new, !(q.st == H_IDLE || q.st == H_HOLD)};
      end
      else if (araddr == `A_DIV)
      begin
        d.rdata = {16'h0000, q.div};
      end
      else if (araddr != `A_TX)
      begin
        d.rresp = `RESP_SLVERR;
      end
    end
    case (q.st)
      H_IDLE:
      begin
        if (start)
        begin
          d.cs_n = 1'b0;
          d.tx = nb;
          d.cnt = rl;
          d.st = H_LEAD;
        end
      end
      H_LEAD:
      begin
        if (tick)
        begin
          d.sclk = 1'b0;
          d.serial_in_line = q.tx[7];
          d.tx = {q.tx[6:0], 1'b0};
          d.bitcnt = '0;
          d.cnt = rl;
          d.st = H_LOW;
        end
      end
      H_LOW:
      begin
        if (tick)
        begin
          d.sclk = 1'b1;
          d.rxsh = {q.rxsh[6:0], q.sdx_s[1]};
          d.cnt = rl;
          d.st = H_HIGH;
        end
      end
      H_HIGH:
      begin
        if (tick)
        begin
          d.cnt = rl;
          if (q.bitcnt == `LAST_BIT_IDX)
          begin
            d.rx = q.rxsh;
            if (q.last)
            begin
              d.cs_n = 1'b1;
              d.st = H_IDLE;
            end
            else
            begin
              d.st = H_HOLD;
            end
          end
          else
          begin
            d.bitcnt = q.bitcnt + 3'h1;
            d.sclk = 1'b0;
            d.serial_in_line = q.tx[7];
            d.tx = {q.tx[6:0], 1'b0};
            d.st = H_LOW;
          end
        end
      end
      H_HOLD:
      begin
        if (start)
        begin
          d.sclk = 1'b0;
          d.serial_in_line = nb[7];
          d.tx = {nb[6:0], 1'b0};
          d.bitcnt = '0;
          d.cnt = rl;
          d.st = H_LOW;
        end
      end
      default:
      begin
        d.st = H_IDLE;
      end
    endcase
    // New byte flag: set wins over the read clear
    if (q.st == H_HIGH && tick && q.bitcnt == `LAST_BIT_IDX)
    begin
      d.rx_new = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.sdx_s <= 2'h3;
      q.div <= `DIV_RESET;
      q.st <= H_IDLE;
      q.cs_n <= 1'b1;
      q.sclk <= 1'b1;
      q.serial_in_line <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign link.sclk = q.sclk;
  assign link.cs_n = q.cs_n;
  assign link.serial_in_line = q.serial_in_line;
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
endmodule : spi_reg_host

// File: testbench/spi_link_asserts.sv
// Checker for the four-wire link between the two ends
module spi_link_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link lines
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in_line,
  input wire logic sdx_o,
  input wire logic sdx_oe,
  input wire logic serial_out_line
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Margins of eight assume the reset divider of ten
  a_sclk_idle_high: assert property (cs_n |-> sclk)
    else $error("sclk low outside frame");
  a_cs_lead_time: assert property ($fell(cs_n) |-> sclk [*8])
    else $error("sclk moved too soon after select");
  a_sclk_low_half: assert property ($fell(sclk) |-> (!sclk && !cs_n) [*8])
    else $error("short sclk low phase");
  a_sdr_on_fall: assert property ((!cs_n && $changed(serial_in_line)) |-> $fell(sclk))
    else $error("sdr moved off a falling edge");
  a_sdx_steady_rise: assert property (($rose(sclk) && !cs_n) |-> $stable(serial_out_line))
    else $error("sdx moved at sampling edge");
  a_sdx_moves_low: assert property
    (($changed(serial_out_line) && $past(sdx_oe) && sdx_oe && !cs_n) |-> !sclk)
    else $error("sdx moved while sclk high");
  a_oe_starts_low: assert property ($rose(sdx_oe) |-> (!sclk && !cs_n))
    else $error("sdx driven outside a slot");
  // Sync latency lets the driver linger a few cycles after select rises
  a_oe_off_idle: assert property (cs_n [*6] |-> !sdx_oe)
    else $error("sdx still driven after frame end");
  c_frame_start: cover property ($fell(cs_n));
  c_read_drive: cover property ($rose(sdx_oe));
  c_frame_end: cover property ($rose(cs_n));
endmodule : spi_link_asserts

// File: testbench/tb_serial_register_access_port.sv
// Self-checking bench for both ends of the serial register-access link
`include "spi_link_defs.svh"
module tb_serial_register_access_port;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_link_pkg::*;
  `define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
    $display("mismatch at %0t: %h vs %h", $time, a, e); end end
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic wr_strap = 1'b0;
  logic rd_strap = 1'b0;
  logic ale_strap = 1'b0;
  logic [7:0] irq_src = 8'h00;
  logic int_o, int_oe, out_pad_drive_select, reg_wr_pulse;
  logic [6:0] reg_wr_addr;
  logic [7:0] reg_wr_data;
  iface_t iface;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  int mismatches = 0;
  int checks_done = 0;
  int wr_cnt = 0;
  int od_bad = 0;
  int n;
  logic [7:0] rxq[$];
  logic [31:0] r;
  logic [1:0] resp;

  always #4 aclk = ~aclk;

  spi_link_if link_if ();
  spi_reg_dev spi_reg_dev_i (.aclk, .aresetn, .link(link_if), .wr_strap, .rd_strap, .ale_strap,
    .irq_src, .int_o, .int_oe, .iface, .out_pad_drive_select, .reg_wr_pulse, .reg_wr_addr,
    .reg_wr_data);
  spi_reg_host spi_reg_host_i (.aclk, .aresetn, .link(link_if), .awaddr, .awvalid, .awready,
    .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);
  spi_link_asserts spi_link_asserts_i (.aclk, .aresetn, .sclk(link_if.sclk),
    .cs_n(link_if.cs_n), .serial_in_line(link_if.serial_in_line), .sdx_o(link_if.sdx_o), .sdx_oe(link_if.sdx_oe),
    .serial_out_line(link_if.serial_out_line));

  // Write strobes counted; a driven one in open-drain mode is a pad fault
  always @(posedge aclk)
  begin
    if (reg_wr_pulse === 1'b1)
      wr_cnt++;
    if (link_if.sdx_oe === 1'b1 && link_if.sdx_o === 1'b1 && out_pad_drive_select === 1'b0)
      od_bad++;
  end

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    r = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_read

  // One select frame; the last byte raises select again
  task automatic frame(input logic [7:0] b[$]);
    rxq = {};
    foreach (b[i])
    begin
      axi_write(`A_TX, {23'h00_0000, 1'(i == b.size() - 1), b[i]});
      do axi_read(`A_STAT); while (r[1] !== 1'b1);
      axi_read(`A_RX);
      rxq.push_back(r[7:0]);
    end
  endtask : frame

  task t_straps;
    `CHK(iface, IF_SERIAL)
    wr_strap <= 1'b1;
    rd_strap <= 1'b1;
    repeat (6) @(posedge aclk);
    `CHK(iface, IF_SERIAL)
    `CHK(int_oe, 1'b0)
    irq_src <= 8'h3C;
    repeat (3) @(posedge aclk);
    `CHK(int_oe, 1'b1)
    `CHK(int_o, 1'b0)
    // A zero divider would stall the link, so it is dropped quietly
    axi_write(`A_DIV, 32'h0000_0000);
    `CHK(resp, `RESP_OKAY)
    axi_read(`A_DIV);
    `CHK(r, {16'h0000, `DIV_RESET})
    axi_read(4'h2);
    `CHK(resp, `RESP_SLVERR)
    axi_write(4'h2, 32'h0000_0000);
    `CHK(resp, `RESP_SLVERR)
    $display("test straps done");
  endtask : t_straps

  // Straps held through a fresh reset; the idle host keeps select high
  task automatic strap_reset(input logic wr, input logic rd, input logic ale);
    wr_strap <= wr;
    rd_strap <= rd;
    ale_strap <= ale;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask : strap_reset

  task t_par_straps;
    strap_reset(1'b1, 1'b1, 1'b1);
    `CHK(iface, IF_PAR_STROBE)
    `CHK(link_if.serial_in_line, 1'b1)
    ale_strap <= 1'b0;
    repeat (6) @(posedge aclk);
    `CHK(iface, IF_PAR_STROBE)
    strap_reset(1'b1, 1'b1, 1'b0);
    `CHK(iface, IF_PAR_PLAIN)
    strap_reset(1'b0, 1'b0, 1'b0);
    `CHK(iface, IF_SERIAL)
    $display("test strap reset done");
  endtask : t_par_straps

  task t_hdr40;
    `CHK(out_pad_drive_select, 1'b0)
    n = wr_cnt;
    frame({`HDR_ADAD_NI, 8'h70, 8'h01, 8'h05, 8'hA5, 8'h85, 8'h00});
    `CHK(wr_cnt, n + 2)
    `CHK(reg_wr_addr, 7'h05)
    `CHK(reg_wr_data, 8'hA5)
    `CHK(out_pad_drive_select, 1'b1)
    `CHK(rxq[6], 8'hA5)
    frame({`HDR_ADAD_NI, 8'h70, 8'h00, 8'h85, 8'h00});
    `CHK(rxq[4], 8'hA5)
    `CHK(od_bad, 0)
    $display("test header 40 done");
  endtask : t_hdr40

  task t_hdr48;
    frame({`HDR_ADAD_IL, 8'h85, 8'hF1, 8'h06, 8'h5A});
    `CHK(rxq[2], 8'hA5)
    `CHK(rxq[3], 8'h3C)
    `CHK(reg_wr_addr, 7'h06)
    `CHK(reg_wr_data, 8'h5A)
    $display("test header 48 done");
  endtask : t_hdr48

  task t_hdr43;
    n = wr_cnt;
    frame({`HDR_ADDD_RW, 8'h02, 8'h11, 8'h22});
    `CHK(wr_cnt, n + 2)
    `CHK(reg_wr_addr, 7'h03)
    frame({`HDR_ADDD_RW, 8'h82, 8'h00, 8'h00});
    `CHK(rxq[2], 8'h11)
    `CHK(rxq[3], 8'h22)
    $display("test header 43 done");
  endtask : t_hdr43

  task t_hdr41_49;
    n = wr_cnt;
    frame({`HDR_ADDD_NI, 8'hF1, 8'h00, 8'h20, 8'h77, 8'h78});
    `CHK(rxq[2], 8'h3C)
    `CHK(wr_cnt, n + 2)
    `CHK(reg_wr_addr, 7'h20)
    `CHK(reg_wr_data, 8'h78)
    frame({`HDR_ADDD_IL, 8'hF1, 8'h21, 8'h66});
    `CHK(rxq[2], 8'h3C)
    `CHK(wr_cnt, n + 3)
    `CHK(reg_wr_addr, 7'h21)
    $display("test header 41 and 49 done");
  endtask : t_hdr41_49

  task t_frames;
    n = wr_cnt;
    frame({`HDR_ADAD_NI, 8'h05});
    frame({`HDR_ADAD_NI, 8'h07, 8'h44});
    `CHK(wr_cnt, n + 1)
    `CHK(reg_wr_addr, 7'h07)
    frame({8'h42, 8'h08, 8'h55});
    `CHK(wr_cnt, n + 1)
    $display("test framing done");
  endtask : t_frames

  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    t_straps();
    t_par_straps();
    t_hdr40();
    t_hdr48();
    t_hdr43();
    t_hdr41_49();
    t_frames();
    finish_test();
  end

  // Some forty bytes of about two hundred cycles each, with ample slack
  initial
  begin
    #400000;
    mismatches++;
    finish_test();
  end
endmodule : tb_serial_register_access_port
